// ===== src/ltis_defines.vh
`ifndef LTIS_DEFINES_VH
`define LTIS_DEFINES_VH

// Command codes
`define LTIS_CMD_CONFIG 8'h00
`define LTIS_CMD_UPPER 8'h01
`define LTIS_CMD_LOWER 8'h02
`define LTIS_CMD_POWER 8'h03
`define LTIS_CMD_FLAGS 8'h06

// Configuration word fields
`define LTIS_CFG_SHUTDOWN 0
`define LTIS_CFG_IRQ_EN 1
`define LTIS_CFG_PERS_LO 4
`define LTIS_CFG_PERS_HI 5
`define LTIS_CFG_IT_LO 6
`define LTIS_CFG_IT_HI 9

// Power-saving word fields
`define LTIS_PWR_AUTO_EN 0
`define LTIS_PWR_MODE_LO 1
`define LTIS_PWR_MODE_HI 2

// Flag word fields
`define LTIS_FLAG_BELOW 15
`define LTIS_FLAG_ABOVE 14

// Reset values
`define LTIS_CONFIG_RST 16'h0001
`define LTIS_UPPER_RST 16'hFFFF
`define LTIS_LOWER_RST 16'h0000
`define LTIS_POWER_RST 3'h0

// Integration period codes
`define LTIS_IT_100 4'h0
`define LTIS_IT_200 4'h1
`define LTIS_IT_400 4'h2
`define LTIS_IT_800 4'h3
`define LTIS_IT_50 4'h8
`define LTIS_IT_25 4'hC

// Times in milliseconds
`define LTIS_IT_25_MS 13'd25
`define LTIS_IT_50_MS 13'd50
`define LTIS_IT_100_MS 13'd100
`define LTIS_IT_200_MS 13'd200
`define LTIS_IT_400_MS 13'd400
`define LTIS_IT_800_MS 13'd800
`define LTIS_GAP_BASE_MS 13'd500

// Clock rate and cycles per millisecond
`define LTIS_CLK_KHZ 250000
`define LTIS_MS_CYCLES (`LTIS_CLK_KHZ * 1)

`endif

// ===== src/ltis_persist.v
`timescale 1ns/1ps
`include "ltis_defines.vh"

module ltis_persist (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Sample stream
   input wire sample,
   input wire beyond,
   input wire [1:0] pers_sel,
   // Event
   output reg hit
);
   reg [3:0] run_reg;
   reg [3:0] run_next;
   wire [3:0] need;

   assign need = 4'h1 << pers_sel;

   always @* begin
      run_next = run_reg;
      if (sample) begin
         if (!beyond) begin
            run_next = 4'h0;
         end else if (run_reg < need) begin
            run_next = run_reg + 4'h1;
         end
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         run_reg <= 4'h0;
         hit <= 1'b0;
      end else begin
         run_reg <= run_next;
         // Any miss restarts the run
         hit <= sample && beyond && (run_next >= need);
      end
   end
endmodule

// ===== src/ltis_core.v
`timescale 1ns/1ps
`include "ltis_defines.vh"

// Overview of operation
// - Config bit 1 enables the threshold interrupt; zero disables it.
// - Config bits 5:4 select 1, 2, 4 or 8 consecutive qualifying results.
// - Flag sets only after the selected count of results stay beyond limit.
// - Command 01 holds a 16-bit read/write upper limit.
// - Command 02 holds a 16-bit read/write lower limit.
// - Status command 06 bit 15 is the read-only below-limit flag; 13:0 reserved.
// - Status command 06 bit 14 is the read-only above-limit flag.
// - Command 03 bit 0 enables low-power self-timed measurements.
// - Command 03 bits 2:1 select modes 1 to 4, resetting to mode 1.
// - Config bits 9:6 select integration time 25, 50, 100, 200, 400 or 800 ms.
// - Config bit 0 set keeps the light channel shut down.

module ltis_core #(
   parameter integer MS_CYCLES = `LTIS_MS_CYCLES,
   parameter integer DATA_W = 16
) (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Command port
   input wire [7:0] cmd,
   input wire wr_en,
   input wire [15:0] wr_data,
   input wire rd_en,
   output reg [15:0] rd_data_reg,
   // Converter
   input wire [DATA_W-1:0] light_count,
   output reg integrating_reg,
   output reg sample_reg,
   // Flags as seen by the command port
   output reg below_limit_flag,
   output reg above_limit_flag
);
   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_INTEG = 2'd1;
   localparam [1:0] ST_GAP = 2'd2;

   reg [15:0] light_config;
   reg [15:0] upper_limit_reg;
   reg [15:0] lower_limit_reg;
   reg [2:0] power_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [31:0] tick_reg;
   reg [12:0] ms_reg;
   reg [12:0] ms_next;
   reg [12:0] integ_ms;
   reg [12:0] gap_ms;
   reg [15:0] rd_next;
   reg sample_next;

   wire light_shutdown;
   wire threshold_irq_enable;
   wire [1:0] persistence_count_select;
   wire [3:0] integration_period_select;
   wire low_power_auto_enable;
   wire [1:0] low_power_interval_select;
   wire ms_tick;
   wire flags_read;
   wire [1:0] beyond;
   wire [1:0] hit;
   wire [15:0] flag_word;

   assign light_shutdown = light_config[`LTIS_CFG_SHUTDOWN];
   assign threshold_irq_enable = light_config[`LTIS_CFG_IRQ_EN];
   assign persistence_count_select = light_config[`LTIS_CFG_PERS_HI:`LTIS_CFG_PERS_LO];
   assign integration_period_select = light_config[`LTIS_CFG_IT_HI:`LTIS_CFG_IT_LO];
   assign low_power_auto_enable = power_reg[`LTIS_PWR_AUTO_EN];
   assign low_power_interval_select = power_reg[`LTIS_PWR_MODE_HI:`LTIS_PWR_MODE_LO];
   assign ms_tick = (tick_reg == MS_CYCLES - 1);
   assign flags_read = rd_en && (cmd == `LTIS_CMD_FLAGS);

   // Reserved bits 13:0 read as zero
   assign flag_word = {below_limit_flag, above_limit_flag, 14'h0000};

   // Register writes
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         light_config <= `LTIS_CONFIG_RST;
         upper_limit_reg <= `LTIS_UPPER_RST;
         lower_limit_reg <= `LTIS_LOWER_RST;
         power_reg <= `LTIS_POWER_RST;
      end else if (wr_en) begin
         case (cmd)
            `LTIS_CMD_CONFIG: light_config <= wr_data;
            `LTIS_CMD_UPPER: upper_limit_reg <= wr_data;
            `LTIS_CMD_LOWER: lower_limit_reg <= wr_data;
            `LTIS_CMD_POWER: power_reg <= wr_data[2:0];
            default: power_reg <= power_reg;
         endcase
      end
   end

   // Read data, one cycle after the strobe
   always @* begin
      case (cmd)
         `LTIS_CMD_CONFIG: rd_next = light_config;
         `LTIS_CMD_UPPER: rd_next = upper_limit_reg;
         `LTIS_CMD_LOWER: rd_next = lower_limit_reg;
         `LTIS_CMD_POWER: rd_next = {13'h0000, power_reg};
         `LTIS_CMD_FLAGS: rd_next = flag_word;
         default: rd_next = 16'h0000;
      endcase
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data_reg <= 16'h0000;
      end else if (rd_en) begin
         rd_data_reg <= rd_next;
      end
   end

   // Integration period lookup
   always @* begin
      case (integration_period_select)
         `LTIS_IT_25: integ_ms = `LTIS_IT_25_MS;
         `LTIS_IT_50: integ_ms = `LTIS_IT_50_MS;
         `LTIS_IT_200: integ_ms = `LTIS_IT_200_MS;
         `LTIS_IT_400: integ_ms = `LTIS_IT_400_MS;
         `LTIS_IT_800: integ_ms = `LTIS_IT_800_MS;
         default: integ_ms = `LTIS_IT_100_MS;
      endcase
      // Gap doubles per mode step
      gap_ms = `LTIS_GAP_BASE_MS << low_power_interval_select;
   end

   // Millisecond prescaler, restarted with each phase
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_reg <= 32'h0000_0000;
      end else if (state_reg == ST_IDLE || ms_tick) begin
         tick_reg <= 32'h0000_0000;
      end else begin
         tick_reg <= tick_reg + 32'h0000_0001;
      end
   end

   // Measurement schedule
   always @* begin
      state_next = state_reg;
      ms_next = ms_reg;
      sample_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (!light_shutdown) begin
               state_next = ST_INTEG;
               ms_next = 13'd0;
            end
         end
         ST_INTEG: begin
            if (ms_tick) begin
               ms_next = ms_reg + 13'd1;
               if (ms_next >= integ_ms) begin
                  sample_next = 1'b1;
                  ms_next = 13'd0;
                  // Without auto mode the next integration follows at once
                  state_next = low_power_auto_enable ? ST_GAP : ST_INTEG;
               end
            end
         end
         ST_GAP: begin
            if (ms_tick) begin
               ms_next = ms_reg + 13'd1;
               if (ms_next >= gap_ms) begin
                  ms_next = 13'd0;
                  state_next = ST_INTEG;
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
            ms_next = 13'd0;
         end
      endcase
      // Shutdown abandons any phase in progress
      if (light_shutdown) begin
         state_next = ST_IDLE;
         ms_next = 13'd0;
         sample_next = 1'b0;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         ms_reg <= 13'd0;
         sample_reg <= 1'b0;
         integrating_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ms_reg <= ms_next;
         sample_reg <= sample_next;
         integrating_reg <= (state_next == ST_INTEG);
      end
   end

   // Window compare on the sampled result
   assign beyond[0] = (light_count > upper_limit_reg);
   assign beyond[1] = (light_count < lower_limit_reg);

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_dir
         ltis_persist u_persist (
            .clk(clk),
            .rstn(rstn),
            .sample(sample_next && threshold_irq_enable),
            .beyond(beyond[g]),
            .pers_sel(persistence_count_select),
            .hit(hit[g])
         );
      end
   endgenerate

   // Sticky flags; a new event wins over the read clear
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         above_limit_flag <= 1'b0;
         below_limit_flag <= 1'b0;
      end else begin
         above_limit_flag <= hit[0] | (above_limit_flag & ~flags_read);
         below_limit_flag <= hit[1] | (below_limit_flag & ~flags_read);
      end
   end
endmodule

// ===== sim/ltis_core_sva.sv
`timescale 1ns/1ps
module ltis_chk (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Command port
   input wire [7:0] cmd,
   input wire wr_en,
   input wire [15:0] wr_data,
   input wire rd_en,
   input wire [15:0] rd_data_reg,
   // Converter and flags
   input wire [15:0] light_count,
   input wire integrating_reg,
   input wire sample_reg,
   input wire below_limit_flag,
   input wire above_limit_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence wr_then_rd(c);
      wr_en && cmd == c ##1 !wr_en ##1 rd_en && !wr_en && cmd == c;
   endsequence
   chk_upper_rw: assert property (wr_then_rd(8'h01) |=> rd_data_reg == $past(wr_data, 3))
      else $error("upper limit readback wrong");
   chk_lower_rw: assert property (wr_then_rd(8'h02) |=> rd_data_reg == $past(wr_data, 3))
      else $error("lower limit readback wrong");
   chk_status_read: assert property (rd_en && cmd == 8'h06 |=>
      rd_data_reg == {$past(below_limit_flag), $past(above_limit_flag), 14'h0000})
      else $error("status word wrong");
   // A fresh hit in the read cycle keeps its flag; flags trail the sample pulse by one cycle
   chk_read_clear: assert property (rd_en && cmd == 8'h06 |=>
      $past(sample_reg) || !(above_limit_flag || below_limit_flag))
      else $error("flags not cleared by read");
   chk_above_cause: assert property ($rose(above_limit_flag) |-> $past(sample_reg))
      else $error("above flag set without sample");
   chk_below_cause: assert property ($rose(below_limit_flag) |-> $past(sample_reg))
      else $error("below flag set without sample");
   chk_power_read: assert property (rd_en && cmd == 8'h03 |=> rd_data_reg[15:3] == 13'h0000)
      else $error("power word upper bits not zero");
   chk_shutdown_idle: assert property (wr_en && cmd == 8'h00 && wr_data[0] |-> ##3 !integrating_reg)
      else $error("shutdown did not stop integration");
   chk_sample_pulse: assert property (sample_reg |=> !sample_reg)
      else $error("sample pulse too long");
endmodule

bind ltis_core ltis_chk chk (.clk, .rstn, .cmd, .wr_en, .wr_data, .rd_en, .rd_data_reg,
   .light_count, .integrating_reg, .sample_reg, .below_limit_flag, .above_limit_flag);

// ===== sim/ltis_host.sv
`timescale 1ns/1ps
module ltis_host (
   // Clock and read data
   input wire clk,
   input wire [15:0] rd_data,
   // Command port
   output var logic [7:0] cmd,
   output var logic wr_en,
   output var logic [15:0] wr_data,
   output var logic rd_en
);
   initial begin
      cmd = 8'h00;
      wr_en = 1'b0;
      wr_data = 16'h0000;
      rd_en = 1'b0;
   end
   // One access per call; the idle cycle after it keeps strobes from merging
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
      output logic [15:0] q);
      @(negedge clk);
      cmd = c;
      wr_data = d;
      wr_en = w;
      rd_en = !w;
      @(negedge clk);
      wr_en = 1'b0;
      rd_en = 1'b0;
      q = rd_data;
   endtask
endmodule

// ===== sim/light_threshold_irq_scheduler_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module light_threshold_irq_scheduler_bench;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] lc = 16'h0000;
   logic [15:0] q;
   wire [7:0] cmd;
   wire wr_en, rd_en, integ, smp, below, above;
   wire [15:0] wr_data, rd_data;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   initial forever #2 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // One cycle per ms keeps the longest interval near 5000 cycles
   ltis_core #(.MS_CYCLES(1)) dut (.clk(clk), .rstn(rstn), .cmd(cmd), .wr_en(wr_en),
      .wr_data(wr_data), .rd_en(rd_en), .rd_data_reg(rd_data), .light_count(lc),
      .integrating_reg(integ), .sample_reg(smp), .below_limit_flag(below),
      .above_limit_flag(above));
   ltis_host host (.clk(clk), .rd_data(rd_data), .cmd(cmd), .wr_en(wr_en),
      .wr_data(wr_data), .rd_en(rd_en));
   task automatic close_out;
      if (n_fail == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      host.xfer(1'b1, c, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
      host.xfer(1'b0, c, 16'h0000, q);
      `CHK(q, e)
   endtask
   task automatic wait_smp;
      int i;
      @(negedge clk);
      for (i = 0; i < 2000 && smp !== 1'b1; i++) @(negedge clk);
      `CHK(smp, 1'b1)
   endtask
   task automatic rise;
      int i;
      for (i = 0; i < 6000 && integ === 1'b1; i++) @(negedge clk);
      for (i = 0; i < 6000 && integ !== 1'b1; i++) @(negedge clk);
   endtask
   initial begin
      #(60000 * 4);
      n_fail++;
      close_out;
   end
   initial begin
      int m, k, i;
      logic [15:0] v;
      logic [1:0] e2;
      static logic [15:0] rst_v [5] = '{16'h0001, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000};
      void'($urandom(18819));
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      for (i = 0; i < 5; i++) rd_chk(i[7:0], rst_v[i]);
      for (i = 0; i < 4; i++) begin
         v = $urandom;
         wr(8'h01, v);
         rd_chk(8'h01, v);
         wr(8'h02, ~v);
         rd_chk(8'h02, ~v);
         wr(8'h03, v);
         rd_chk(8'h03, v & 16'h0007);
         wr(8'h00, v | 16'h0001);
         rd_chk(8'h00, v | 16'h0001);
         wr(8'h06, v);
      end
      rd_chk(8'h06, 16'h0000);
      wr(8'h03, 16'h0000);
      wr(8'h01, 16'h8000);
      wr(8'h02, 16'h0100);
      for (m = 0; m < 4; m++) begin
         lc = 16'h0100 + 16'($urandom % 32'h7F01);
         wr(8'h00, 16'(m << 4) | 16'h0002);
         wait_smp;
         lc = m[0] ? 16'h8001 + 16'($urandom % 32'h7FFF) : 16'($urandom % 32'h0100);
         for (k = 1; k <= (1 << m); k++) begin
            wait_smp;
            // Flags register one cycle after the sample pulse
            @(negedge clk);
            e2 = (k == (1 << m)) ? (m[0] ? 2'b01 : 2'b10) : 2'b00;
            `CHK({below, above}, e2)
         end
         rd_chk(8'h06, m[0] ? 16'h4000 : 16'h8000);
         `CHK({below, above}, 2'b00)
      end
      lc = 16'hFFFF;
      for (m = 0; m < 4; m++) begin
         wr(8'h03, 16'(m << 1) | 16'h0001);
         wr(8'h00, 16'(m << 6));
         rise;
         rise;
         k = cyc;
         rise;
         `CHK(cyc - k, 600 << m)
      end
      rd_chk(8'h06, 16'h0000);
      wr(8'h00, 16'h0001);
      repeat (2) @(negedge clk);
      `CHK(integ, 1'b0)
      close_out;
   end
endmodule
